// ---- rtl/cpu_port_pkg.sv ----
// Function
// RQ1 - an eight-bit bidirectional peripheral port lives on chip
// RQ2 - output value register answers reads and writes at 0001, ahead of external memory
// RQ3 - direction register answers reads and writes at 0000, ahead of external memory
// RQ4 - every port pin has its own direction bit, any mix allowed
// RQ5 - sixteen-bit address bus can float so other masters share memory
// RQ6 - data bus is driven through tri-state buffers, both directions
// RQ7 - system supplies the clock or controls the clock generator
// RQ8 - the clock must not run the processor slower than 50 kHz
// RQ9 - no bus write happens while the init input is low
// RQ10 - a rising edge on the init input starts the init sequence at once
// RQ11 - after six init cycles set mask, load counter from FFFC and FFFD
// RQ12 - at power up init is held low at least two cycles
// RQ13 - address, direction line and data bus float while drive enable is low
// RQ14 - direction line stays high except during device write cycles
// RQ15 - direction bit one drives the output register bit, zero makes an input
package cpu_port_pkg;
    localparam int ADDR_W        = 16;
    localparam int DATA_W        = 8;
    localparam int PORT_W        = 8;
    localparam logic [15:0] PORT_DIR_ADDR = 16'h0000;
    localparam logic [15:0] PORT_OUT_ADDR = 16'h0001;
    localparam logic [15:0] VEC_LO_ADDR   = 16'hFFFC;
    localparam logic [15:0] VEC_HI_ADDR   = 16'hFFFD;
    localparam logic [7:0]  PORT_DIR_RST  = 8'h00;
    localparam logic [7:0]  PORT_OUT_RST  = 8'h00;
    localparam logic [2:0]  INIT_CYCLES   = 3'h6;
    localparam int CLK_PERIOD_NS = 8;
    localparam int CPU_CYCLE_NS  = 1000;
    localparam int MIN_CPU_KHZ   = 50;
    localparam int CYC_DIV_DEF   = CPU_CYCLE_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {ST_HOLD, ST_INIT, ST_VEC_LO, ST_VEC_HI, ST_RUN} seq_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        write;
    } busReq_s;
endpackage : cpu_port_pkg

// ---- rtl/pin_sync3.sv ----
`timescale 1ns/1ns
module pin_sync3 #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,  // system clock
    input  wire logic         rst_n,    // sync reset, active low
    input  wire logic [W-1:0] pinIn,    // raw pin levels
    output logic      [W-1:0] pinOut    // filtered levels
);
    logic [W-1:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;

    // a bit changes only once stages two and three agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s2_r[i] : filt_r[i];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s1_r   <= '0;
            s2_r   <= '0;
            s3_r   <= '0;
            filt_r <= '0;
        end else begin
            s1_r   <= pinIn;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            filt_r <= filt_nxt;
        end
    end

    assign pinOut = filt_r;
endmodule : pin_sync3

// ---- rtl/cpu_bus_port.sv ----
`timescale 1ns/1ns
module cpu_bus_port
    import cpu_port_pkg::*;
#(
    parameter int CYC_DIV = CYC_DIV_DEF
) (
    input  wire logic              sys_clk,        // 125 MHz clock
    input  wire logic              rst_n,          // sync reset, active low
    input  wire logic              cpuInitIn,      // init pin, low holds the device
    input  wire logic              busDriveEnIn,   // bus drive enable pin
    output logic [ADDR_W-1:0]      addrOut,        // address lines level
    output logic                   addrOe,         // address lines driven
    output logic                   rwOut,          // transfer direction, high = read
    output logic                   rwOe,           // direction line driven
    input  wire logic [DATA_W-1:0] dataIn,         // data lines as seen on pins
    output logic [DATA_W-1:0]      dataOut,        // data lines drive value
    output logic                   dataOe,         // data lines driven
    input  wire logic [PORT_W-1:0] portIn,         // peripheral port pins in
    output logic [PORT_W-1:0]      portOut,        // peripheral port pins out
    output logic [PORT_W-1:0]      portOe,         // per-pin drive enable
    input  wire logic              reqValid,       // core access request
    input  wire busReq_s           req,            // address, data, write flag
    output logic                   reqReady,       // request taken this cycle
    output logic                   rspValid,       // access finished, pulse
    output logic [DATA_W-1:0]      rspData,        // read data
    output logic                   vecValid,       // start vector ready, pulse
    output logic [ADDR_W-1:0]      vecAddr,        // start address for program counter
    output logic                   maskSet         // set interrupt mask, pulse
);
    logic [DATA_W+PORT_W+1:0] syncOut;
    logic                     initLvl, driveEnLvl;
    logic [DATA_W-1:0]        dataLvl;
    logic [PORT_W-1:0]        portLvl;

    // one shared filter gives every pin the same lag, so data and enables stay aligned
    pin_sync3 #(.W(DATA_W+PORT_W+2)) u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .pinIn   ({cpuInitIn, busDriveEnIn, dataIn, portIn}),
        .pinOut  (syncOut)
    );
    assign {initLvl, driveEnLvl, dataLvl, portLvl} = syncOut;

    // one cpu cycle is CYC_DIV clocks; tick marks its last clock
    logic [15:0] div_r, div_nxt;
    logic        tick;
    assign tick = (div_r == 16'(CYC_DIV - 1));

    seq_e              state_r, state_nxt;
    logic [2:0]        cnt_r, cnt_nxt;
    logic              initPrev_r, initPrev_nxt;
    logic              busy_r, busy_nxt;
    busReq_s           cur_r, cur_nxt;
    logic              internal_r, internal_nxt;
    logic [PORT_W-1:0] dir_r, dir_nxt, outv_r, outv_nxt;
    logic [DATA_W-1:0] rsp_r, rsp_nxt, vecLo_r, vecLo_nxt;
    logic              rspV_r, rspV_nxt, vecV_r, vecV_nxt;
    logic [ADDR_W-1:0] vec_r, vec_nxt;
    logic              rw_r, rw_nxt, dOe_r, dOe_nxt;
    logic [PORT_W-1:0] portView;
    logic              initRise, startOk;
    busReq_s           vecReq;

    // readback of the port: output bits show the register, input bits the pin
    generate
        for (genvar b = 0; b < PORT_W; b++) begin : g_port
            assign portOe[b]   = dir_r[b];                              // [RQ4] [RQ15]
            assign portView[b] = dir_r[b] ? outv_r[b] : portLvl[b];     // [RQ1]
        end
    endgenerate
    assign portOut = outv_r;                                            // [RQ15]

    // the filter resets low, so a pin already high at release still counts as a rise
    assign initRise = initLvl && !initPrev_r;                           // [RQ10]
    // accesses start on a cycle boundary and only while this device owns the bus
    assign startOk  = tick && !busy_r && driveEnLvl && initLvl;
    assign reqReady = (state_r == ST_RUN) && startOk;
    // vector fetches are plain reads that the core never sees as responses
    assign vecReq   = '{addr: (state_r == ST_VEC_HI) ? VEC_HI_ADDR : VEC_LO_ADDR,
                        wdata: 8'h00, write: 1'b0};

    always_comb begin
        div_nxt      = tick ? 16'h0000 : div_r + 16'h0001;
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        initPrev_nxt = initLvl;
        busy_nxt     = busy_r;
        cur_nxt      = cur_r;
        internal_nxt = internal_r;
        dir_nxt      = dir_r;
        outv_nxt     = outv_r;
        rsp_nxt      = rsp_r;
        rspV_nxt     = 1'b0;
        vecV_nxt     = 1'b0;
        vec_nxt      = vec_r;
        vecLo_nxt    = vecLo_r;
        // finish the running access at the next cycle boundary
        if (busy_r && tick) begin
            busy_nxt = 1'b0;
            if (internal_r) begin
                // the old value answers, so a write returns the readback from before it, pin levels included for input bits
                if (cur_r.addr == PORT_DIR_ADDR) begin
                    if (cur_r.write) dir_nxt = cur_r.wdata;             // [RQ3]
                    rsp_nxt = dir_r;                                    // [RQ3]
                end else begin
                    if (cur_r.write) outv_nxt = cur_r.wdata;            // [RQ2]
                    rsp_nxt = portView;                                 // [RQ2]
                end
            end else begin
                // read data pass the pin filter, so memory must settle early in the cycle
                rsp_nxt = dataLvl;                                      // [RQ6]
            end
            case (state_r)
                ST_VEC_LO: begin
                    vecLo_nxt = dataLvl;
                    state_nxt = ST_VEC_HI;
                end
                ST_VEC_HI: begin
                    vec_nxt   = {dataLvl, vecLo_r};                     // [RQ11]
                    vecV_nxt  = 1'b1;
                    state_nxt = ST_RUN;
                end
                default: rspV_nxt = 1'b1;
            endcase
        end
        case (state_r)
            ST_HOLD: begin
                if (initRise) begin
                    state_nxt = ST_INIT;                                // [RQ10]
                    cnt_nxt   = 3'h0;
                end
            end
            // cycle boundaries are counted, so a release mid-cycle waits five whole cycles plus the rest of the current one
            ST_INIT: begin
                if (tick) begin
                    if (cnt_r == INIT_CYCLES - 3'h1) state_nxt = ST_VEC_LO; // [RQ11]
                    cnt_nxt = cnt_r + 3'h1;
                end
            end
            ST_VEC_LO, ST_VEC_HI: begin
                if (startOk && !(busy_r && tick)) begin
                    busy_nxt     = 1'b1;
                    cur_nxt      = vecReq;
                    internal_nxt = 1'b0;
                end
            end
            // only the two port addresses stay inside; all others go out on the bus
            ST_RUN: begin
                if (reqReady && reqValid) begin
                    busy_nxt     = 1'b1;
                    cur_nxt      = req;
                    internal_nxt = (req.addr == PORT_DIR_ADDR) ||
                                   (req.addr == PORT_OUT_ADDR);         // [RQ2] [RQ3]
                end
            end
            default: state_nxt = ST_HOLD;
        endcase
        // a low init level aborts any access not finishing this cycle, drops the pulses and holds the device
        if (!initLvl) begin
            state_nxt = ST_HOLD;                                        // [RQ9]
            busy_nxt  = 1'b0;
            rspV_nxt  = 1'b0;
            vecV_nxt  = 1'b0;
        end
        // direction line low only for an external write the device is running
        rw_nxt  = !(busy_nxt && cur_nxt.write && !internal_nxt && initLvl); // [RQ14] [RQ9]
        // data drive follows rw, so the pins never fight memory during a read
        dOe_nxt = !rw_nxt;                                              // [RQ6]
    end

    // registers only; every next value is chosen in the process above
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            div_r      <= 16'h0000;
            state_r    <= ST_HOLD;
            cnt_r      <= 3'h0;
            initPrev_r <= 1'b0;
            busy_r     <= 1'b0;
            cur_r      <= '0;
            internal_r <= 1'b0;
            dir_r      <= PORT_DIR_RST;
            outv_r     <= PORT_OUT_RST;
            rsp_r      <= 8'h00;
            rspV_r     <= 1'b0;
            vecV_r     <= 1'b0;
            vec_r      <= 16'h0000;
            vecLo_r    <= 8'h00;
            rw_r       <= 1'b1;
            dOe_r      <= 1'b0;
        end else begin
            div_r      <= div_nxt;
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            initPrev_r <= initPrev_nxt;
            busy_r     <= busy_nxt;
            cur_r      <= cur_nxt;
            internal_r <= internal_nxt;
            dir_r      <= dir_nxt;
            outv_r     <= outv_nxt;
            rsp_r      <= rsp_nxt;
            rspV_r     <= rspV_nxt;
            vecV_r     <= vecV_nxt;
            vec_r      <= vec_nxt;
            vecLo_r    <= vecLo_nxt;
            rw_r       <= rw_nxt;
            dOe_r      <= dOe_nxt;
        end
    end

    // the bus floats as soon as the filtered drive enable drops
    assign addrOut  = cur_r.addr;
    assign addrOe   = driveEnLvl;                                       // [RQ5] [RQ13]
    assign rwOut    = rw_r;                                             // [RQ14]
    assign rwOe     = driveEnLvl;                                       // [RQ13]
    assign dataOut  = cur_r.wdata;
    assign dataOe   = dOe_r && driveEnLvl;                              // [RQ6] [RQ13]
    assign rspValid = rspV_r;
    assign rspData  = rsp_r;
    assign vecValid = vecV_r;
    assign vecAddr  = vec_r;
    // mask and vector share one pulse; the core takes both together
    assign maskSet  = vecV_r;                                           // [RQ11]
endmodule : cpu_bus_port

// ---- test/cpu_bus_port_monitor.sv ----
`timescale 1ns/1ns
module cpu_bus_port_monitor
    import cpu_port_pkg::*;
#(
    parameter int CYC_DIV = CYC_DIV_DEF
) (
    input wire logic              sys_clk,      // clock
    input wire logic              rst_n,        // sync reset
    input wire logic              cpuInitIn,    // init pin
    input wire logic              busDriveEnIn, // drive enable pin
    input wire logic              addrOe,       // address driven
    input wire logic              rwOut,        // direction line
    input wire logic              rwOe,         // direction driven
    input wire logic              dataOe,       // data driven
    input wire logic [PORT_W-1:0] portOut,      // port levels
    input wire logic [PORT_W-1:0] portOe,       // port enables
    input wire logic              reqValid,     // request
    input wire busReq_s           req,          // request fields
    input wire logic              reqReady,     // request taken
    input wire logic              rspValid,     // access done
    input wire logic              vecValid,     // vector ready
    input wire logic              maskSet       // mask pulse
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    localparam int RSP_LAT = CYC_DIV + 1;
    logic    take;
    busReq_s last_r;
    assign take = reqValid && reqReady;
    always_ff @(posedge sys_clk) begin
        if (take) last_r <= req;
    end
    property p_rw_low; $fell(rwOut) |-> $past(take && req.write); endproperty
    a_rw_low: assert property (p_rw_low) else $error("rw fell without a write");
    property p_init_hold; !cpuInitIn [*6] |-> !reqReady && rwOut; endproperty
    a_init_hold: assert property (p_init_hold) else $error("access while init low");
    property p_float; !busDriveEnIn [*5] |-> !addrOe && !rwOe && !dataOe; endproperty
    a_float: assert property (p_float) else $error("bus driven while disabled");
    property p_drive; busDriveEnIn [*5] |-> addrOe && rwOe; endproperty
    a_drive: assert property (p_drive) else $error("address bus not driven");
    property p_internal; take && req.addr[15:1] == 15'h0 |=> (rwOut && !dataOe) [*7]; endproperty
    a_internal: assert property (p_internal) else $error("internal access on bus");
    property p_rsp; take && cpuInitIn |-> ##RSP_LAT rspValid; endproperty
    a_rsp: assert property (p_rsp) else $error("response late or missing");
    property p_dir;
        rspValid && last_r.write && last_r.addr == PORT_DIR_ADDR |-> portOe == last_r.wdata;
    endproperty
    a_dir: assert property (p_dir) else $error("direction register not written");
    property p_out;
        rspValid && last_r.write && last_r.addr == PORT_OUT_ADDR |-> portOut == last_r.wdata;
    endproperty
    a_out: assert property (p_out) else $error("output register not written");
    property p_vec; (vecValid || maskSet) |-> vecValid && maskSet && !rspValid; endproperty
    a_vec: assert property (p_vec) else $error("mask not set with vector");
    c_vec: cover property (vecValid);
    c_write: cover property (take && req.write && req.addr[15:1] != 15'h0);
    c_float: cover property (!addrOe && rst_n);
endmodule : cpu_bus_port_monitor

// ---- test/bus_memory.sv ----
`timescale 1ns/1ns
module bus_memory
    import cpu_port_pkg::*;
#(
    parameter int LAT = 2 // read data valid from LAT+1 cycles after an address change
) (
    input  wire logic              sys_clk,  // clock
    input  wire logic [ADDR_W-1:0] addrOut,  // address from device
    input  wire logic              addrOe,   // address driven
    input  wire logic              rwOut,    // high = read
    input  wire logic [DATA_W-1:0] dataOut,  // device data
    input  wire logic              dataOe,   // device drives data
    output logic      [DATA_W-1:0] dataBus   // resolved data lines
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  lastVal;
    logic [15:0] addrSeen;
    int          age;
    initial begin
        mem[16'hFFFC] = 8'h34;
        mem[16'hFFFD] = 8'h12;
        lastVal = 8'h00;
        age = 0;
        addrSeen = 16'h0000;
    end
    always @(posedge sys_clk) begin
        age      <= (addrOut == addrSeen) ? age + 1 : 0;
        addrSeen <= addrOut;
        if (dataOe && !rwOut) mem[addrOut] <= dataOut;
        lastVal  <= dataBus;
    end
    // undriven lines show the inverse so a stale value never passes
    always_comb begin
        if (dataOe) dataBus = dataOut;
        else if (addrOe && rwOut && age >= LAT) dataBus = mem[addrOut];
        else dataBus = ~lastVal;
    end
endmodule : bus_memory

// ---- test/test_cpu_bus_port.sv ----
`timescale 1ns/1ns
module test_cpu_bus_port;
    import cpu_port_pkg::*;
    localparam int DIV = 8;
    logic        sys_clk, rst_n, cpuInitIn, busDriveEnIn, addrOe, rwOut, rwOe, dataOe;
    logic        reqValid, reqReady, rspValid, vecValid, maskSet;
    logic [15:0] addrOut, vecAddr;
    logic [7:0]  dataOut, dataBus, portIn, portOut, portOe, rspData, rd;
    busReq_s     req;
    int          fail_count, checked;
    cpu_bus_port #(.CYC_DIV(DIV)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
        .cpuInitIn(cpuInitIn), .busDriveEnIn(busDriveEnIn), .addrOut(addrOut),
        .addrOe(addrOe), .rwOut(rwOut), .rwOe(rwOe), .dataIn(dataBus), .dataOut(dataOut),
        .dataOe(dataOe), .portIn(portIn), .portOut(portOut), .portOe(portOe),
        .reqValid(reqValid), .req(req), .reqReady(reqReady), .rspValid(rspValid),
        .rspData(rspData), .vecValid(vecValid), .vecAddr(vecAddr), .maskSet(maskSet));
    bus_memory mem_u (.sys_clk(sys_clk), .addrOut(addrOut), .addrOe(addrOe), .rwOut(rwOut),
        .dataOut(dataOut), .dataOe(dataOe), .dataBus(dataBus));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic access(input logic [15:0] a, input logic [7:0] d, input logic w);
        int n;
        req = '{a, d, w};
        reqValid = 1'b1;
        n = 0;
        while (reqReady !== 1'b1 && n < 300) begin @(negedge sys_clk); n++; end
        @(negedge sys_clk);
        reqValid = 1'b0;
        check("addrOut", addrOut, a);
        check("rwOut", {15'h0, rwOut}, {15'h0, !(w && a[15:1] != 15'h0)});
        n = 0;
        while (rspValid !== 1'b1 && n < 40) begin @(negedge sys_clk); n++; end
        check("rspValid", {15'h0, rspValid}, 16'h1);
        rd = rspData;
    endtask : access
    task automatic wait_vec();
        int n;
        n = 0;
        while (vecValid !== 1'b1 && n < 400) begin @(negedge sys_clk); n++; end
        check("vecValid", {15'h0, vecValid}, 16'h1);
        check("maskSet", {15'h0, maskSet}, 16'h1);
        check("vecAddr", vecAddr, 16'h1234);
    endtask : wait_vec
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    initial begin
        #200000;
        fail_count++;
        wrap_up();
    end
    initial begin
        {rst_n, cpuInitIn, busDriveEnIn, reqValid} = 4'b0010;
        req = '0;
        portIn = 8'h3C;
        fail_count = 0;
        checked = 0;
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        cpuInitIn = 1'b1;
        wait_vec();
        $display("test vector done");
        access(PORT_DIR_ADDR, 8'h0F, 1'b1);
        access(PORT_OUT_ADDR, 8'hA5, 1'b1);
        check("portOe", {8'h0, portOe}, 16'h000F);
        check("portOut", {8'h0, portOut}, 16'h00A5);
        access(PORT_DIR_ADDR, 8'h00, 1'b0);
        check("dirRead", {8'h0, rd}, 16'h000F);
        access(PORT_OUT_ADDR, 8'h00, 1'b0);
        check("portRead", {8'h0, rd}, 16'h0035);
        $display("test port done");
        access(16'h1234, 8'h5A, 1'b1);
        access(16'h0002, 8'hC3, 1'b1);
        access(16'h1234, 8'h00, 1'b0);
        check("extRead", {8'h0, rd}, 16'h005A);
        access(16'h0002, 8'h00, 1'b0);
        check("extRead2", {8'h0, rd}, 16'h00C3);
        $display("test bus done");
        busDriveEnIn = 1'b0;
        repeat (6) @(negedge sys_clk);
        check("float", {13'h0, addrOe, rwOe, dataOe}, 16'h0000);
        busDriveEnIn = 1'b1;
        repeat (6) @(negedge sys_clk);
        check("drive", {14'h0, addrOe, rwOe}, 16'h0003);
        $display("test enable done");
        cpuInitIn = 1'b0;
        repeat (6) @(negedge sys_clk);
        req = '{16'h1234, 8'hEE, 1'b1};
        reqValid = 1'b1;
        repeat (20) @(negedge sys_clk);
        reqValid = 1'b0;
        check("rwHigh", {14'h0, rwOut, dataOe}, 16'h0002);
        cpuInitIn = 1'b1;
        wait_vec();
        access(16'h1234, 8'h00, 1'b0);
        check("noWrite", {8'h0, rd}, 16'h005A);
        $display("test init done");
        wrap_up();
    end
endmodule : test_cpu_bus_port
bind cpu_bus_port cpu_bus_port_monitor #(.CYC_DIV(CYC_DIV)) mon_u (.sys_clk(sys_clk),
    .rst_n(rst_n), .cpuInitIn(cpuInitIn), .busDriveEnIn(busDriveEnIn), .addrOe(addrOe),
    .rwOut(rwOut), .rwOe(rwOe), .dataOe(dataOe), .portOut(portOut), .portOe(portOe),
    .reqValid(reqValid), .req(req), .reqReady(reqReady), .rspValid(rspValid),
    .vecValid(vecValid), .maskSet(maskSet));
